/* logic/parb_arbiter.sv */
// parb_arbiter: central arbiter with board glue logic sharing pair 0
// assumes link requests are synchronous to CLK; pulled-up slot lines read high
`timescale 1ns/100ps
module parb_arbiter (
   input  wire logic  CLK,
   input  wire logic  RST_N,
   parb_link_if.arb   LINK,
   input  wire logic  HOST_REQ,
   output logic       HOST_GNT,
   output logic [3:0] OWNER
);
   ////////////////////////////////////////////////////////////////////////////
   // requests, active high inside
   logic                       req_a;
   logic                       req_b;
   logic                       hold_req;
   logic [parb_pkg::NUM_RR-1:0] rr_req;
   parb_pkg::parb_owner_t      owner;
   parb_pkg::parb_owner_t      next_owner;
   logic [2:0]                 last;
   logic [2:0]                 next_last;
   logic                       pref;
   logic                       next_pref;
   logic                       owner_req;

   assign req_a    = ~LINK.shared_pair_side_a_req_n;
   assign req_b    = ~LINK.shared_pair_side_b_req_n;
   assign hold_req = ~LINK.southbridge_hold_req_n;

   always_comb
   begin
      rr_req         = '0;
      rr_req[0]      = req_a | req_b;
      rr_req[4:1]    = ~LINK.pair_req_n;
      rr_req[parb_pkg::RR_HOST] = HOST_REQ;
   end

   ////////////////////////////////////////////////////////////////////////////
   // request still held by the current owner
   always_comb
   begin
      case (owner)
         parb_pkg::PARB_HOST   : owner_req = HOST_REQ;
         parb_pkg::PARB_HOLD   : owner_req = hold_req;
         parb_pkg::PARB_SIDE_A : owner_req = req_a;
         parb_pkg::PARB_SIDE_B : owner_req = req_b;
         parb_pkg::PARB_PAIR1  : owner_req = rr_req[1];
         parb_pkg::PARB_PAIR2  : owner_req = rr_req[2];
         parb_pkg::PARB_PAIR3  : owner_req = rr_req[3];
         parb_pkg::PARB_PAIR4  : owner_req = rr_req[4];
         default               : owner_req = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // pair 0 side pick: preferred side only on a tie
   function automatic logic side_sel(input logic p, input logic a, input logic b);
      if (a && b)
      begin
         side_sel = p;
      end
      else if (b)
      begin
         side_sel = parb_pkg::SIDE_B;
      end
      else
      begin
         side_sel = parb_pkg::SIDE_A;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next owner: hold first, then rotation over pairs and host
   always_comb
   begin
      logic       found;
      logic [2:0] idx;
      logic       side;
      found      = 1'b0;
      idx        = 3'h0;
      side       = side_sel(pref, req_a, req_b);
      next_owner = owner;
      next_last  = last;
      next_pref  = pref;
      case (owner)
         parb_pkg::PARB_IDLE :
         begin
            if (hold_req)
            begin
               next_owner = parb_pkg::PARB_HOLD;
            end
            else
            begin
               for (int i = 1; i <= parb_pkg::NUM_RR; i++)
               begin
                  idx = 3'((32'(last) + i) % parb_pkg::NUM_RR);
                  if (!found && rr_req[idx])
                  begin
                     found     = 1'b1;
                     next_last = idx;
                  end
               end
               if (found)
               begin
                  case (next_last)
                     3'h0 :
                     begin
                        next_owner = side ? parb_pkg::PARB_SIDE_B
                                          : parb_pkg::PARB_SIDE_A;
                        next_pref  = ~side;
                     end
                     3'h1    : next_owner = parb_pkg::PARB_PAIR1;
                     3'h2    : next_owner = parb_pkg::PARB_PAIR2;
                     3'h3    : next_owner = parb_pkg::PARB_PAIR3;
                     3'h4    : next_owner = parb_pkg::PARB_PAIR4;
                     default : next_owner = parb_pkg::PARB_HOST;
                  endcase
               end
            end
         end
         parb_pkg::PARB_HOLD :
         begin
            if (!hold_req)
            begin
               next_owner = parb_pkg::PARB_IDLE;
            end
         end
         default :
         begin
            // release, or preempt so the hold wait stays bounded
            if (!owner_req || hold_req)
            begin
               next_owner = parb_pkg::PARB_IDLE;
            end
         end
      endcase
   end

   localparam logic SIDE_A = parb_pkg::SIDE_A;
   localparam logic SIDE_B = parb_pkg::SIDE_B;

   ////////////////////////////////////////////////////////////////////////////
   // owner state
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         owner <= parb_pkg::PARB_IDLE;
      end
      else
      begin
         owner <= next_owner;
      end
   end

   // rotation pointer and pair 0 side preference
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         last <= parb_pkg::RR_RESET;
         pref <= SIDE_A;
      end
      else
      begin
         last <= next_last;
         pref <= next_pref;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // grants, at most one low at a time
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         LINK.pair_gnt_n               <= 4'hF;
         LINK.shared_pair_side_a_gnt_n <= 1'b1;
         LINK.shared_pair_side_b_gnt_n <= 1'b1;
         LINK.southbridge_hold_ack_n   <= 1'b1;
         HOST_GNT                      <= 1'b0;
         OWNER                         <= 4'h0;
      end
      else
      begin
         LINK.pair_gnt_n[1] <= (next_owner != parb_pkg::PARB_PAIR1);
         LINK.pair_gnt_n[2] <= (next_owner != parb_pkg::PARB_PAIR2);
         LINK.pair_gnt_n[3] <= (next_owner != parb_pkg::PARB_PAIR3);
         LINK.pair_gnt_n[4] <= (next_owner != parb_pkg::PARB_PAIR4);
         LINK.shared_pair_side_a_gnt_n <= (next_owner != parb_pkg::PARB_SIDE_A);
         LINK.shared_pair_side_b_gnt_n <= (next_owner != parb_pkg::PARB_SIDE_B);
         LINK.southbridge_hold_ack_n   <= (next_owner != parb_pkg::PARB_HOLD);
         HOST_GNT                      <= (next_owner == parb_pkg::PARB_HOST);
         OWNER                         <= next_owner;
      end
   end
endmodule // parb_arbiter

/* logic/parb_pkg.sv */
// parb_pkg: constants and types shared by the arbiter end and the master end
// assumes one PCI clock domain for both ends
package parb_pkg;
   localparam int         NUM_MASTERS = 8;  // nic, four slots, scsi, south bridge, host
   localparam int         NUM_PAIRS   = 5;  // external request/grant pairs 0..4
   localparam int         NUM_RR      = 6;  // rotation members: pairs 0..4 plus host
   localparam int         RR_HOST     = 5;  // rotation index of the host bridge
   localparam int         BUS_WIDTH   = 32;
   localparam int         CLK_MHZ     = 33;
   localparam logic [2:0] RR_RESET    = 3'h5;  // rotation starts after host
   localparam logic       SIDE_A      = 1'b0;
   localparam logic       SIDE_B      = 1'b1;
   // link requester order on the master end
   localparam int         M_SLOT1     = 0;
   localparam int         M_SLOT2     = 1;
   localparam int         M_SLOT3     = 2;
   localparam int         M_SLOT4     = 3;
   localparam int         M_NIC       = 4;
   localparam int         M_SBRIDGE   = 5;
   localparam int         NUM_LINK_M  = 6;

   typedef enum logic [3:0] {
      PARB_IDLE   = 4'b0000,
      PARB_HOST   = 4'b0001,
      PARB_HOLD   = 4'b0010,
      PARB_SIDE_A = 4'b0011,
      PARB_SIDE_B = 4'b0100,
      PARB_PAIR1  = 4'b0101,
      PARB_PAIR2  = 4'b0110,
      PARB_PAIR3  = 4'b0111,
      PARB_PAIR4  = 4'b1000
   } parb_owner_t;
endpackage

/* logic/parb_link_if.sv */
// parb_link_if: request/grant wires between the arbiter and the bus masters
// assumes both ends run on the same PCI clock
`timescale 1ns/100ps
interface parb_link_if;
   logic [4:1] pair_req_n;
   logic [4:1] pair_gnt_n;
   logic       shared_pair_side_a_req_n;
   logic       shared_pair_side_a_gnt_n;
   logic       shared_pair_side_b_req_n;
   logic       shared_pair_side_b_gnt_n;
   logic       southbridge_hold_req_n;
   logic       southbridge_hold_ack_n;

   modport arb (
      input  pair_req_n,
      output pair_gnt_n,
      input  shared_pair_side_a_req_n,
      output shared_pair_side_a_gnt_n,
      input  shared_pair_side_b_req_n,
      output shared_pair_side_b_gnt_n,
      input  southbridge_hold_req_n,
      output southbridge_hold_ack_n
   );

   modport mst (
      output pair_req_n,
      input  pair_gnt_n,
      output shared_pair_side_a_req_n,
      input  shared_pair_side_a_gnt_n,
      output shared_pair_side_b_req_n,
      input  shared_pair_side_b_gnt_n,
      output southbridge_hold_req_n,
      input  southbridge_hold_ack_n
   );
endinterface

/* logic/parb_masters.sv */
// parb_masters: request side of slots, nic, scsi and south bridge
// assumes grants arrive synchronous to CLK from the arbiter end
`timescale 1ns/100ps
module parb_masters (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   parb_link_if.mst         LINK,
   input  wire logic [5:0]  MREQ,
   input  wire logic [3:0]  SLOT_PRESENT,
   input  wire logic        SCSI_WIDE_REQ,
   input  wire logic        SCSI_NARROW_REQ,
   output logic      [5:0]  MGNT,
   output logic             SCSI_WIDE_GNT,
   output logic             SCSI_NARROW_GNT
);
   ////////////////////////////////////////////////////////////////////////////
   // scsi channel choice, held while its request stands
   logic       scsi_sel;
   logic       scsi_busy;
   logic       scsi_req;
   logic [5:0] live;
   logic [5:0] gnt;

   assign scsi_req = scsi_sel ? SCSI_NARROW_REQ : SCSI_WIDE_REQ;

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         scsi_sel  <= 1'b0;
         scsi_busy <= 1'b0;
      end
      else if (!scsi_busy)
      begin
         if (SCSI_WIDE_REQ && (!SCSI_NARROW_REQ || scsi_sel))
         begin
            scsi_sel  <= 1'b0;
            scsi_busy <= 1'b1;
         end
         else if (SCSI_NARROW_REQ)
         begin
            scsi_sel  <= 1'b1;
            scsi_busy <= 1'b1;
         end
      end
      else if (!scsi_req)
      begin
         scsi_busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // requests: empty slots leave the line high
   always_comb
   begin
      live        = MREQ;
      live[3:0]   = MREQ[3:0] & SLOT_PRESENT;
   end

   // grant counts only while our request is on the link, not a stale one
   assign gnt[parb_pkg::M_SLOT1]   = ~LINK.shared_pair_side_a_gnt_n
                                     & ~LINK.shared_pair_side_a_req_n;
   assign gnt[parb_pkg::M_SLOT2]   = ~LINK.pair_gnt_n[1] & ~LINK.pair_req_n[1];
   assign gnt[parb_pkg::M_SLOT3]   = ~LINK.pair_gnt_n[2] & ~LINK.pair_req_n[2];
   assign gnt[parb_pkg::M_SLOT4]   = ~LINK.pair_gnt_n[3] & ~LINK.pair_req_n[3];
   assign gnt[parb_pkg::M_NIC]     = ~LINK.pair_gnt_n[4] & ~LINK.pair_req_n[4];
   assign gnt[parb_pkg::M_SBRIDGE] = ~LINK.southbridge_hold_ack_n
                                     & ~LINK.southbridge_hold_req_n;

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         LINK.shared_pair_side_a_req_n <= 1'b1;
         LINK.shared_pair_side_b_req_n <= 1'b1;
         LINK.pair_req_n               <= 4'hF;
         LINK.southbridge_hold_req_n   <= 1'b1;
      end
      else
      begin
         LINK.shared_pair_side_a_req_n <= ~live[parb_pkg::M_SLOT1];
         LINK.shared_pair_side_b_req_n <= ~(scsi_busy & scsi_req);
         LINK.pair_req_n[1]            <= ~live[parb_pkg::M_SLOT2];
         LINK.pair_req_n[2]            <= ~live[parb_pkg::M_SLOT3];
         LINK.pair_req_n[3]            <= ~live[parb_pkg::M_SLOT4];
         LINK.pair_req_n[4]            <= ~live[parb_pkg::M_NIC];
         LINK.southbridge_hold_req_n   <= ~live[parb_pkg::M_SBRIDGE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus ownership seen by each master
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         MGNT            <= 6'h00;
         SCSI_WIDE_GNT   <= 1'b0;
         SCSI_NARROW_GNT <= 1'b0;
      end
      else
      begin
         MGNT            <= gnt & live;
         SCSI_WIDE_GNT   <= ~LINK.shared_pair_side_b_gnt_n & scsi_busy & ~scsi_sel;
         SCSI_NARROW_GNT <= ~LINK.shared_pair_side_b_gnt_n & scsi_busy & scsi_sel;
      end
   end
endmodule // parb_masters

/* tb/parb_checker.sv */
// parb_checker: link protocol assertions between arbiter and masters
// assumes one clock domain; inputs are the link interface wires
`timescale 1ns/100ps
module parb_checker (
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic [4:1] pair_req_n,
   input wire logic [4:1] pair_gnt_n,
   input wire logic       shared_pair_side_a_req_n,
   input wire logic       shared_pair_side_a_gnt_n,
   input wire logic       shared_pair_side_b_req_n,
   input wire logic       shared_pair_side_b_gnt_n,
   input wire logic       southbridge_hold_req_n,
   input wire logic       southbridge_hold_ack_n
);
   logic [6:0] gv;
   logic       any;
   assign gv  = ~{southbridge_hold_ack_n, shared_pair_side_b_gnt_n,
                  shared_pair_side_a_gnt_n, pair_gnt_n};
   assign any = |gv;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////////
   one_grant_a: assert property ($onehot0(gv))
      else $error("two grants low at once");
   pair_cause_a: assert property ((~pair_gnt_n & $past(pair_req_n)) == 4'h0)
      else $error("pair grant without request");
   side_a_drop_a: assert property (shared_pair_side_a_req_n |=> shared_pair_side_a_gnt_n)
      else $error("side a grant without request");
   side_b_drop_a: assert property (shared_pair_side_b_req_n |=> shared_pair_side_b_gnt_n)
      else $error("side b grant without request");
   hold_drop_a: assert property (southbridge_hold_req_n |=> southbridge_hold_ack_n)
      else $error("hold ack without hold request");
   hold_ack_a: assert property ($fell(southbridge_hold_req_n) |->
      ##[1:3] (!southbridge_hold_ack_n || southbridge_hold_req_n))
      else $error("hold ack late");
   hold_first_a: assert property (!southbridge_hold_req_n |=> gv[5:0] == 6'h00)
      else $error("grant kept during hold request");
   pair_wait_a: assert property ($fell(pair_req_n[1]) |->
      ##[1:60] (!pair_gnt_n[1] || pair_req_n[1]))
      else $error("pair 1 request not served");
   no_handover_a: assert property (any && $past(any) |-> $stable(gv))
      else $error("owner changed without idle cycle");
   side_turn_a: assert property ($rose(shared_pair_side_a_gnt_n) &&
      !shared_pair_side_b_req_n |-> shared_pair_side_a_gnt_n throughout
      (##[1:80] (!shared_pair_side_b_gnt_n || shared_pair_side_b_req_n)))
      else $error("side a served twice in a row");
endmodule // parb_checker

/* tb/tb.sv */
// tb: arbiter and masters joined by the link, driven from the user sides
// assumes a 40 ns clock and a synchronous active-low reset
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
module tb;
   localparam logic [3:0] own_code [9] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h2, 4'h4, 4'h4, 4'h1};
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [5:0] mreq = 6'h00;
   logic [3:0] present = 4'hF;
   logic       wide = 1'b0;
   logic       narrow = 1'b0;
   logic       host = 1'b0;
   logic [5:0] mgnt;
   logic       wide_gnt;
   logic       narrow_gnt;
   logic       host_gnt;
   logic [3:0] owner;
   logic [8:0] gv;
   logic [8:0] prev = 9'h000;
   logic [7:0] note;
   logic [7:0] notes [$];
   int         errors = 0;
   int         checks_done = 0;
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   parb_link_if i_parb_link_if ();
   parb_arbiter i_parb_arbiter (.CLK(clk), .RST_N(rst_n), .LINK(i_parb_link_if),
      .HOST_REQ(host), .HOST_GNT(host_gnt), .OWNER(owner));
   parb_masters i_parb_masters (.CLK(clk), .RST_N(rst_n), .LINK(i_parb_link_if),
      .MREQ(mreq), .SLOT_PRESENT(present), .SCSI_WIDE_REQ(wide),
      .SCSI_NARROW_REQ(narrow), .MGNT(mgnt), .SCSI_WIDE_GNT(wide_gnt),
      .SCSI_NARROW_GNT(narrow_gnt));
   parb_checker i_parb_checker (.CLK(clk), .RST_N(rst_n),
      .pair_req_n(i_parb_link_if.pair_req_n), .pair_gnt_n(i_parb_link_if.pair_gnt_n),
      .shared_pair_side_a_req_n(i_parb_link_if.shared_pair_side_a_req_n),
      .shared_pair_side_a_gnt_n(i_parb_link_if.shared_pair_side_a_gnt_n),
      .shared_pair_side_b_req_n(i_parb_link_if.shared_pair_side_b_req_n),
      .shared_pair_side_b_gnt_n(i_parb_link_if.shared_pair_side_b_gnt_n),
      .southbridge_hold_req_n(i_parb_link_if.southbridge_hold_req_n),
      .southbridge_hold_ack_n(i_parb_link_if.southbridge_hold_ack_n));
   ////////////////////////////////////////////////////////////////////////////
   // each rising grant takes the oldest note: owner code and grant index
   assign gv = {host_gnt, narrow_gnt, wide_gnt, mgnt};
   always @(posedge clk)
   begin
      for (int i = 0; i < 9; i++)
         if (gv[i] === 1'b1 && prev[i] !== 1'b1)
         begin
            note = (notes.size() > 0) ? notes.pop_front() : 8'hFF;
            `CHK("grant", note, {owner, 4'(i)})
         end
      prev <= gv;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #2;
      end
   endtask
   task automatic set_req(input int i, input logic v);
      if (i < 6)
         mreq[i] = v;
      else if (i == 6)
         wide = v;
      else if (i == 7)
         narrow = v;
      else
         host = v;
   endtask
   task automatic wait_gnt(input int i, input logic v);
      int n;
      n = 0;
      while (gv[i] !== v && n < 200)
      begin
         step(1);
         n++;
      end
      if (n == 200)
      begin
         errors++;
         $display("unexpected grant %0d: expected %0b, seen %0b", i, v, gv[i]);
         print_verdict();
      end
   endtask
   task automatic one(input int i, input int hold);
      notes.push_back({own_code[i], 4'(i)});
      set_req(i, 1'b1);
      wait_gnt(i, 1'b1);
      step(hold);
      set_req(i, 1'b0);
      wait_gnt(i, 1'b0);
      step(2);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(37073));
      step(16);
      rst_n = 1'b1;
      step(1);
      for (int i = 0; i < 9; i++)
         one(i, 2);
      $display("test single done");
      present = 4'hE;
      set_req(0, 1'b1);
      step(20);
      `CHK("absent slot request", 1'b1, i_parb_link_if.shared_pair_side_a_req_n)
      `CHK("absent slot grant", 1'b0, mgnt[0])
      set_req(0, 1'b0);
      present = 4'hF;
      $display("test absent done");
      notes.push_back({own_code[0], 4'h0});
      notes.push_back({own_code[6], 4'h6});
      notes.push_back({own_code[0], 4'h0});
      set_req(0, 1'b1);
      set_req(6, 1'b1);
      wait_gnt(0, 1'b1);
      step(3);
      set_req(0, 1'b0);
      wait_gnt(0, 1'b0);
      set_req(0, 1'b1);
      wait_gnt(6, 1'b1);
      step(3);
      set_req(6, 1'b0);
      wait_gnt(0, 1'b1);
      step(3);
      set_req(0, 1'b0);
      wait_gnt(0, 1'b0);
      step(2);
      $display("test round robin done");
      notes.push_back({own_code[1], 4'h1});
      notes.push_back({own_code[5], 4'h5});
      notes.push_back({own_code[1], 4'h1});
      set_req(1, 1'b1);
      wait_gnt(1, 1'b1);
      set_req(5, 1'b1);
      wait_gnt(5, 1'b1);
      step(2);
      set_req(5, 1'b0);
      wait_gnt(1, 1'b1);
      step(2);
      set_req(1, 1'b0);
      wait_gnt(1, 1'b0);
      step(2);
      $display("test hold done");
      notes.push_back({own_code[7], 4'h7});
      notes.push_back({own_code[6], 4'h6});
      set_req(6, 1'b1);
      set_req(7, 1'b1);
      wait_gnt(7, 1'b1);
      step(2);
      set_req(7, 1'b0);
      wait_gnt(6, 1'b1);
      step(2);
      set_req(6, 1'b0);
      wait_gnt(6, 1'b0);
      step(2);
      $display("test scsi done");
      repeat (20)
         one($urandom % 9, 1 + $urandom % 4);
      $display("test random done");
      step(2);
      `CHK("pending notes", 0, notes.size())
      print_verdict();
   end
endmodule // tb
